// File: hw/dck_params.svh
// Constants shared by both ends of the DRAM clock change link.
// Assumes a 250 MHz system clock on the controller end.
`ifndef DCK_PARAMS_SVH
`define DCK_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses), control and status fields
// ----------------------------------------------------------------------
`define DCK_REG_CTRL      12'h000
`define DCK_REG_DIV       12'h004
`define DCK_REG_MR0       12'h008
`define DCK_REG_STAT      12'h00C
`define DCK_CTRL_GO       5'h00
`define DCK_CTRL_USE_SR   5'h01
`define DCK_CTRL_ODT      5'h02
`define DCK_CTRL_UPD      5'h03
`define DCK_STAT_BUSY     5'h00
`define DCK_STAT_DONE     5'h01
`define DCK_STAT_REFUSED  5'h02

// ----------------------------------------------------------------------
// Clock divider: link period is 2 * div system periods
// ----------------------------------------------------------------------
`define DCK_SYS_PERIOD_NS 16'h0004
`define DCK_DIV_RST       8'h02
`define DCK_DIV_MIN       8'h01
`define DCK_DIV_MAX       8'h40

// ----------------------------------------------------------------------
// Timing as clock counts; tCKSRE, tCKSRX, tXP and tXS also as nanoseconds
// ----------------------------------------------------------------------
`define DCK_TCKSRE_NCK    16'h0005
`define DCK_TCKSRE_NS     16'h000A
`define DCK_TCKSRX_NCK    16'h0005
`define DCK_TCKSRX_NS     16'h000A
`define DCK_TXP_NCK       16'h0003
`define DCK_TXP_NS        16'h0006
`define DCK_TXS_NCK       16'h0005
`define DCK_TXS_NS        16'h00AA
`define DCK_TMRD_NCK      16'h0004
`define DCK_TDLLK_NCK     16'h0200
`define DCK_TAOF_NCK      16'h0002

// ----------------------------------------------------------------------
// Mode register selection and bits
// ----------------------------------------------------------------------
`define DCK_MR0           2'h0
`define DCK_MR1           2'h1
`define DCK_MR0_DLL_RST   4'h8
`define DCK_MR1_RTT_NOM   4'h2

`endif

// File: hw/dck_pkg.sv
// Types shared by both ends of the DRAM clock change link.
// Assumes nothing beyond the constants header.
package dck_pkg;

   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_SRE = 3'h1,
      CMD_SRX = 3'h2,
      CMD_PDE = 3'h3,
      CMD_PDX = 3'h4,
      CMD_MRS = 3'h5
   } dck_cmd_e;

   typedef enum logic [3:0] {
      C_IDLE   = 4'h0,
      C_ODTOFF = 4'h1,
      C_ENTER  = 4'h2,
      C_WENT   = 4'h3,
      C_CHG    = 4'h4,
      C_WSTB   = 4'h5,
      C_EXIT   = 4'h6,
      C_WXP    = 4'h7,
      C_DLLRST = 4'h8,
      C_WMRD   = 4'h9,
      C_UPD    = 4'hA,
      C_WLOCK  = 4'hB
   } dck_cstate_e;

   typedef enum logic [1:0] {
      D_IDLE = 2'h0,
      D_SREF = 2'h1,
      D_PPD  = 2'h2
   } dck_dstate_e;

endpackage

// File: hw/dck_link_if.sv
// Link between the memory controller end and the DRAM end.
// Assumes the controller drives every signal; the DRAM only listens.
`timescale 1ns/1ps
`default_nettype none
interface dck_link_if;
   logic              ck;
   logic              cke;
   logic              odt;
   dck_pkg::dck_cmd_e cmd;
   logic [1:0]        mr_sel;
   logic [15:0]       mr_addr;

   modport ctrl (output ck, output cke, output odt, output cmd,
                 output mr_sel, output mr_addr);
   modport dram (input ck, input cke, input odt, input cmd,
                 input mr_sel, input mr_addr);
endinterface
`default_nettype wire

// File: hw/dck_ctrl.sv
// Memory controller end: APB registers, link clock divider and the
// frequency change sequence through self-refresh or power-down.
// Assumes an APB master on SYS_CLK_IN and a DRAM end on the link.
//
// Function
// - Change frequency only in self-refresh or power-down
// - Keep clock period fixed in other states
// - DRAM ignores clock after self-refresh entry wait
// - New clock stable tCKSRX before self-refresh exit
// - Keep normal self-refresh entry and exit timing
// - Keep new frequency within speed grade range
// - Hold ODT low throughout power-down
// - Termination disabled stays off whatever ODT does
// - Wait tCKSRE after CKE low before change
// - Hold ODT and CKE low during change
// - New clock stable tCKSRX before power-down exit
// - After exit and tXP, reset DLL via MRS
// - Update WR, CL, CWL with CKE high
// - During relock ODT low, CKE high, wait lock
// - Meet ODT turn-off timing before change point
// - Count cycle parameters in actual clock edges
// - Convert nanoseconds to cycles, rounding up
// - DLL reset is MR0 bit A8 set
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "dck_params.svh"
module dck_ctrl (
   // System clock and reset
   input  wire logic        SYS_CLK_IN,
   input  wire logic        SYS_RST_IN,
   // APB slave
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [11:0] PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   // Link to the DRAM end
   dck_link_if.ctrl         LINK
);

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   dck_pkg::dck_cstate_e state_q;
   dck_pkg::dck_cmd_e    cmd_q;
   logic [7:0]           div_q;
   logic [7:0]           newdiv_q;
   logic [7:0]           hcnt_q;
   logic                 ck_q;
   logic                 tick;
   logic [15:0]          cnt_q;
   logic [15:0]          mr0_q;
   logic                 use_sr_q;
   logic                 odt_norm_q;
   logic                 upd_q;
   logic                 go_pend_q;
   logic                 done_q;
   logic                 refused_q;
   logic                 cke_q;
   logic                 odt_q;
   logic [1:0]           mrsel_q;
   logic [15:0]          mraddr_q;
   logic [31:0]          prdata_q;
   logic                 wr_en;
   logic                 rd_setup;
   logic                 addr_ok;
   logic                 busy;
   logic                 go_wr;
   logic                 clr_wr;
   logic                 finish;

   // Larger of a cycle count and a rounded-up nanosecond figure
   function automatic logic [15:0] cyc(input logic [15:0] nck,
                                       input logic [15:0] ns,
                                       input logic [7:0]  d);
      logic [15:0] tck;
      logic [15:0] ru;
      tck = 16'({d, 1'b0}) * `DCK_SYS_PERIOD_NS;
      ru  = (ns + tck - 16'h0001) / tck;
      cyc = (ru > nck) ? ru : nck;
   endfunction

   // -------------------------------------------------------------------
   // APB slave, zero wait states
   // -------------------------------------------------------------------
   assign addr_ok  = (PADDR_IN == `DCK_REG_CTRL) || (PADDR_IN == `DCK_REG_DIV) ||
                     (PADDR_IN == `DCK_REG_MR0)  || (PADDR_IN == `DCK_REG_STAT);
   assign wr_en    = PSEL_IN && PENABLE_IN && PWRITE_IN && addr_ok;
   assign rd_setup = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
   assign busy     = (state_q != dck_pkg::C_IDLE) || go_pend_q;
   assign go_wr    = wr_en && (PADDR_IN == `DCK_REG_CTRL) && PWDATA_IN[`DCK_CTRL_GO];
   assign clr_wr   = wr_en && (PADDR_IN == `DCK_REG_STAT);
   assign finish   = tick && (state_q == dck_pkg::C_WLOCK) && (cnt_q == 16'h0000);

   assign PREADY_OUT  = 1'b1;
   assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_ok;
   assign PRDATA_OUT  = prdata_q;

   always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         use_sr_q   <= 1'b0;
         odt_norm_q <= 1'b0;
         upd_q      <= 1'b0;
         newdiv_q   <= `DCK_DIV_RST;
         mr0_q      <= 16'h0000;
      end else if (wr_en && !busy) begin
         if (PADDR_IN == `DCK_REG_CTRL) begin
            use_sr_q   <= PWDATA_IN[`DCK_CTRL_USE_SR];
            odt_norm_q <= PWDATA_IN[`DCK_CTRL_ODT];
            upd_q      <= PWDATA_IN[`DCK_CTRL_UPD];
         end
         if (PADDR_IN == `DCK_REG_DIV) begin
            if (PWDATA_IN[7:0] < `DCK_DIV_MIN)
               newdiv_q <= `DCK_DIV_MIN;
            else if (PWDATA_IN[7:0] > `DCK_DIV_MAX)
               newdiv_q <= `DCK_DIV_MAX;
            else
               newdiv_q <= PWDATA_IN[7:0];
         end
         if (PADDR_IN == `DCK_REG_MR0)
            mr0_q <= PWDATA_IN[15:0];
      end
   end

   always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN)
         prdata_q <= 32'h00000000;
      else if (rd_setup) begin
         unique case (PADDR_IN)
            `DCK_REG_CTRL: prdata_q <= {28'h0000000, upd_q, odt_norm_q, use_sr_q, 1'b0};
            `DCK_REG_DIV:  prdata_q <= {24'h000000, newdiv_q};
            `DCK_REG_MR0:  prdata_q <= {16'h0000, mr0_q};
            `DCK_REG_STAT: prdata_q <= {16'h0000, div_q, state_q, 1'b0,
                                        refused_q, done_q, busy};
            default:       prdata_q <= 32'h00000000;
         endcase
      end
   end

   // Go requests, sticky status; a set wins over a clear
   always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         go_pend_q <= 1'b0;
         done_q    <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         if (go_wr && !busy)
            go_pend_q <= 1'b1;
         else if (tick && (state_q == dck_pkg::C_IDLE))
            go_pend_q <= 1'b0;
         if (finish)
            done_q <= 1'b1;
         else if (clr_wr && PWDATA_IN[`DCK_STAT_DONE])
            done_q <= 1'b0;
         if (go_wr && busy)
            refused_q <= 1'b1;
         else if (clr_wr && PWDATA_IN[`DCK_STAT_REFUSED])
            refused_q <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Link clock divider; tick marks each falling link edge
   // -------------------------------------------------------------------
   assign tick = ck_q && (hcnt_q == div_q - 8'h01);

   always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         hcnt_q <= 8'h00;
         ck_q   <= 1'b0;
      end else if (hcnt_q == div_q - 8'h01) begin
         hcnt_q <= 8'h00;
         ck_q   <= !ck_q;
      end else
         hcnt_q <= hcnt_q + 8'h01;
   end

   // Divider changes only at the sequence's change point
   always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN)
         div_q <= `DCK_DIV_RST;
      else if (tick && (state_q == dck_pkg::C_CHG))
         div_q <= newdiv_q;
   end

   // -------------------------------------------------------------------
   // Sequence, advancing once per link clock (one per actual edge)
   // -------------------------------------------------------------------
   always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         state_q  <= dck_pkg::C_IDLE;
         cnt_q    <= 16'h0000;
         cmd_q    <= dck_pkg::CMD_NOP;
         cke_q    <= 1'b1;
         odt_q    <= 1'b0;
         mrsel_q  <= `DCK_MR0;
         mraddr_q <= 16'h0000;
      end else if (tick) begin
         cmd_q <= dck_pkg::CMD_NOP;
         if (cnt_q != 16'h0000)
            cnt_q <= cnt_q - 16'h0001;
         unique case (state_q)
            dck_pkg::C_IDLE: begin
               cke_q <= 1'b1;
               odt_q <= odt_norm_q;
               if (go_pend_q) begin
                  odt_q   <= 1'b0;
                  cnt_q   <= `DCK_TAOF_NCK;
                  state_q <= dck_pkg::C_ODTOFF;
               end
            end
            dck_pkg::C_ODTOFF: if (cnt_q == 16'h0000) begin
               cke_q   <= 1'b0;
               cmd_q   <= use_sr_q ? dck_pkg::CMD_SRE : dck_pkg::CMD_PDE;
               state_q <= dck_pkg::C_ENTER;
            end
            dck_pkg::C_ENTER: begin
               cnt_q   <= cyc(`DCK_TCKSRE_NCK, `DCK_TCKSRE_NS, div_q);
               state_q <= dck_pkg::C_WENT;
            end
            dck_pkg::C_WENT: if (cnt_q == 16'h0000)
               state_q <= dck_pkg::C_CHG;
            dck_pkg::C_CHG: begin
               cnt_q   <= cyc(`DCK_TCKSRX_NCK, `DCK_TCKSRX_NS, newdiv_q);
               state_q <= dck_pkg::C_WSTB;
            end
            dck_pkg::C_WSTB: if (cnt_q == 16'h0000) begin
               cke_q   <= 1'b1;
               cmd_q   <= use_sr_q ? dck_pkg::CMD_SRX : dck_pkg::CMD_PDX;
               state_q <= dck_pkg::C_EXIT;
            end
            dck_pkg::C_EXIT: begin
               cnt_q   <= use_sr_q ? cyc(`DCK_TXS_NCK, `DCK_TXS_NS, div_q)
                                   : cyc(`DCK_TXP_NCK, `DCK_TXP_NS, div_q);
               state_q <= dck_pkg::C_WXP;
            end
            dck_pkg::C_WXP: if (cnt_q == 16'h0000) begin
               cmd_q    <= dck_pkg::CMD_MRS;
               mrsel_q  <= `DCK_MR0;
               mraddr_q <= mr0_q | (16'h0001 << `DCK_MR0_DLL_RST);
               state_q  <= dck_pkg::C_DLLRST;
            end
            dck_pkg::C_DLLRST: begin
               cnt_q   <= `DCK_TMRD_NCK - 16'h0002;
               state_q <= dck_pkg::C_WMRD;
            end
            dck_pkg::C_WMRD: if (cnt_q == 16'h0000) begin
               if (upd_q) begin
                  cmd_q    <= dck_pkg::CMD_MRS;
                  mraddr_q <= mr0_q & ~(16'h0001 << `DCK_MR0_DLL_RST);
                  state_q  <= dck_pkg::C_UPD;
               end else begin
                  cnt_q   <= `DCK_TDLLK_NCK;
                  state_q <= dck_pkg::C_WLOCK;
               end
            end
            dck_pkg::C_UPD: begin
               cnt_q   <= `DCK_TDLLK_NCK;
               state_q <= dck_pkg::C_WLOCK;
            end
            dck_pkg::C_WLOCK: if (cnt_q == 16'h0000)
               state_q <= dck_pkg::C_IDLE;
            default: state_q <= dck_pkg::C_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Link drive
   // -------------------------------------------------------------------
   assign LINK.ck      = ck_q;
   assign LINK.cke     = cke_q;
   assign LINK.odt     = odt_q;
   assign LINK.cmd     = cmd_q;
   assign LINK.mr_sel  = mrsel_q;
   assign LINK.mr_addr = mraddr_q;

endmodule
`default_nettype wire

// File: hw/dck_dram.sv
// DRAM end: tracks self-refresh and power-down, termination, DLL lock
// and mode register spacing, all on the link clock.
// Assumes the controller end drives the link and its clock.
`timescale 1ns/1ps
`default_nettype none
`include "dck_params.svh"
module dck_dram (
   // Link and reset
   dck_link_if.dram         LINK,
   input  wire logic        LINK_RST_IN,
   // Status
   output logic [1:0]       STATE_OUT,
   output logic             CLK_IGNORED_OUT,
   output logic             RTT_ON_OUT,
   output logic             DLL_LOCKED_OUT,
   output logic             ERR_OUT
);

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   dck_pkg::dck_dstate_e state_q;
   logic [15:0]          ent_cnt_q;
   logic [15:0]          dll_cnt_q;
   logic [15:0]          mrd_cnt_q;
   logic                 rtt_en_q;
   logic                 rtt_on_q;
   logic                 locked_q;
   logic                 err_q;
   logic                 mrs;

   assign mrs = LINK.cke && (LINK.cmd == dck_pkg::CMD_MRS);

   // -------------------------------------------------------------------
   // Power state tracking
   // -------------------------------------------------------------------
   always_ff @(posedge LINK.ck or posedge LINK_RST_IN) begin
      if (LINK_RST_IN) begin
         state_q   <= dck_pkg::D_IDLE;
         ent_cnt_q <= 16'h0000;
      end else begin
         if (ent_cnt_q != 16'hFFFF)
            ent_cnt_q <= ent_cnt_q + 16'h0001;
         unique case (state_q)
            dck_pkg::D_IDLE: if (!LINK.cke) begin
               ent_cnt_q <= 16'h0000;
               state_q   <= (LINK.cmd == dck_pkg::CMD_SRE) ? dck_pkg::D_SREF
                                                            : dck_pkg::D_PPD;
            end
            dck_pkg::D_SREF: if (LINK.cke && (LINK.cmd == dck_pkg::CMD_SRX))
               state_q <= dck_pkg::D_IDLE;
            dck_pkg::D_PPD: if (LINK.cke)
               state_q <= dck_pkg::D_IDLE;
            default: state_q <= dck_pkg::D_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Mode registers, termination and DLL
   // -------------------------------------------------------------------
   always_ff @(posedge LINK.ck or posedge LINK_RST_IN) begin
      if (LINK_RST_IN) begin
         rtt_en_q  <= 1'b0;
         rtt_on_q  <= 1'b0;
         dll_cnt_q <= 16'h0000;
         locked_q  <= 1'b0;
      end else begin
         if (mrs && (LINK.mr_sel == `DCK_MR1))
            rtt_en_q <= LINK.mr_addr[`DCK_MR1_RTT_NOM];
         rtt_on_q <= LINK.odt && rtt_en_q && (state_q == dck_pkg::D_IDLE);
         if (mrs && (LINK.mr_sel == `DCK_MR0) && LINK.mr_addr[`DCK_MR0_DLL_RST]) begin
            dll_cnt_q <= `DCK_TDLLK_NCK;
            locked_q  <= 1'b0;
         end else if (dll_cnt_q != 16'h0000) begin
            dll_cnt_q <= dll_cnt_q - 16'h0001;
            locked_q  <= (dll_cnt_q == 16'h0001);
         end
      end
   end

   // -------------------------------------------------------------------
   // Protocol checks: MRS spacing in edges, ODT and CKE misuse
   // -------------------------------------------------------------------
   always_ff @(posedge LINK.ck or posedge LINK_RST_IN) begin
      if (LINK_RST_IN) begin
         mrd_cnt_q <= 16'h0000;
         err_q     <= 1'b0;
      end else begin
         if (mrs)
            mrd_cnt_q <= `DCK_TMRD_NCK - 16'h0001;
         else if (mrd_cnt_q != 16'h0000)
            mrd_cnt_q <= mrd_cnt_q - 16'h0001;
         if ((mrs && (mrd_cnt_q != 16'h0000)) ||
             ((state_q == dck_pkg::D_PPD) && rtt_en_q && LINK.odt) ||
             ((dll_cnt_q != 16'h0000) && (!LINK.cke || LINK.odt)))
            err_q <= 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign STATE_OUT       = state_q;
   assign CLK_IGNORED_OUT = (state_q != dck_pkg::D_IDLE) &&
                            (ent_cnt_q >= `DCK_TCKSRE_NCK);
   assign RTT_ON_OUT      = rtt_on_q;
   assign DLL_LOCKED_OUT  = locked_q;
   assign ERR_OUT         = err_q;

endmodule
`default_nettype wire

// File: verif/dck_link_properties.sv
// Checker on the signals of the link between controller and DRAM ends.
// Assumes the bench instantiates it beside the interface joining both ends.
`timescale 1ns/1ps
`default_nettype none
module dck_link_properties (
   // Link clock and reset
   input  wire logic              ck,
   input  wire logic              LINK_RST_IN,
   // Link signals
   input  wire logic              cke,
   input  wire logic              odt,
   input  wire dck_pkg::dck_cmd_e cmd,
   input  wire logic [1:0]        mr_sel,
   input  wire logic [15:0]       mr_addr
);
   default clocking cb @(posedge ck); endclocking
   default disable iff (LINK_RST_IN);
   logic [9:0] lk_q;
   logic [3:0] n_q;
   realtime    t_last;
   realtime    per_q;
   realtime    per_prev;
   // ----
   // Relock window and clock period tracking
   // ----
   always_ff @(posedge ck or posedge LINK_RST_IN) begin
      if (LINK_RST_IN) lk_q <= 10'h000;
      else if (cmd == dck_pkg::CMD_MRS && mr_sel == 2'h0 && mr_addr[8]) lk_q <= 10'h1FF;
      else if (lk_q != 10'h000) lk_q <= lk_q - 10'h001;
   end
   always_ff @(posedge ck or posedge LINK_RST_IN) begin
      if (LINK_RST_IN) n_q <= 4'h0;
      else if (n_q != 4'hF) n_q <= n_q + 4'h1;
   end
   always @(posedge ck) begin
      per_prev <= per_q;
      per_q    <= $realtime - t_last;
      t_last   <= $realtime;
   end
   sequence s_dll_reset;
      (cmd == dck_pkg::CMD_MRS) && (mr_sel == 2'h0) && mr_addr[8];
   endsequence
   sequence s_upd_or_nop;
      (cmd == dck_pkg::CMD_NOP) || (cmd == dck_pkg::CMD_MRS && !mr_addr[8]);
   endsequence
   a_mrs_spacing: assert property (
      cmd == dck_pkg::CMD_MRS |=> (cmd != dck_pkg::CMD_MRS) [*3])
      else $error("mode register commands too close");
   a_pdx_dll_reset: assert property (
      cmd == dck_pkg::CMD_PDX |=> (cmd == dck_pkg::CMD_NOP) [*2] ##[1:64] s_dll_reset)
      else $error("no DLL reset after power-down exit");
   a_srx_dll_reset: assert property (
      cmd == dck_pkg::CMD_SRX |=> (cmd == dck_pkg::CMD_NOP) [*4] ##[1:64] s_dll_reset)
      else $error("no DLL reset after self-refresh exit");
   a_upd_spacing: assert property (
      s_dll_reset |=> (cmd == dck_pkg::CMD_NOP) [*3] ##1 s_upd_or_nop)
      else $error("update command misplaced");
   a_relock_hold: assert property (lk_q != 10'h000 |-> cke && !odt)
      else $error("cke or odt moved during relock");
   a_odt_pd_low: assert property (!cke |-> !odt)
      else $error("odt high with cke low");
   a_entry_cmd: assert property (
      $fell(cke) |-> (cmd == dck_pkg::CMD_SRE || cmd == dck_pkg::CMD_PDE)
                     && !$past(odt, 1) && !$past(odt, 2))
      else $error("bad low power entry");
   a_low_hold: assert property ($fell(cke) |-> (!cke) [*8])
      else $error("cke low too short");
   a_exit_cmd: assert property (
      $rose(cke) |-> cmd == dck_pkg::CMD_SRX || cmd == dck_pkg::CMD_PDX)
      else $error("bad low power exit");
   a_period_fixed: assert property (
      (n_q > 4'h4) && cke && $past(cke) && $past(cke, 2) |-> per_q == per_prev)
      else $error("clock period changed while active");
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Bench joining both ends, plus a second DRAM end on a bench-driven link.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "dck_params.svh"
module testbench;
   typedef struct packed {
      logic       sr;
      logic       odt;
      logic       upd;
      logic [7:0] div;
      logic [7:0] dexp;
   } dck_row_s;
   localparam dck_row_s ROWS [4] = '{'{1'b1, 1'b1, 1'b1, 8'h03, 8'h03},
      '{1'b0, 1'b0, 1'b0, 8'h00, 8'h01}, '{1'b0, 1'b1, 1'b1, 8'h02, 8'h02},
      '{1'b1, 1'b0, 1'b0, 8'h01, 8'h01}};
   logic        sys_clk  = 1'b0;
   logic        sys_rst  = 1'b1;
   logic        link_rst = 1'b1;
   logic        rst_b    = 1'b1;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [11:0] paddr    = 12'h000;
   logic [31:0] pwdata   = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [1:0]  st_a;
   logic [1:0]  st_b;
   logic        ign_a;
   logic        ign_b;
   logic        rtt_a;
   logic        rtt_b;
   logic        lock_a;
   logic        lock_b;
   logic        err_a;
   logic        err_b;
   logic [31:0] rd;
   logic        er;
   int          n_errors  = 0;
   int          tests_run = 0;
   int          cyc       = 0;
   dck_link_if u_link ();
   dck_link_if u_link_b ();
   dck_ctrl u_dck_ctrl (.SYS_CLK_IN(sys_clk), .SYS_RST_IN(sys_rst), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .LINK(u_link));
   dck_dram u_dck_dram (.LINK(u_link), .LINK_RST_IN(link_rst), .STATE_OUT(st_a),
      .CLK_IGNORED_OUT(ign_a), .RTT_ON_OUT(rtt_a), .DLL_LOCKED_OUT(lock_a), .ERR_OUT(err_a));
   dck_dram u_dck_dram_b (.LINK(u_link_b), .LINK_RST_IN(rst_b), .STATE_OUT(st_b),
      .CLK_IGNORED_OUT(ign_b), .RTT_ON_OUT(rtt_b), .DLL_LOCKED_OUT(lock_b), .ERR_OUT(err_b));
   dck_link_properties u_dck_link_properties (.ck(u_link.ck), .LINK_RST_IN(link_rst),
      .cke(u_link.cke), .odt(u_link.odt), .cmd(u_link.cmd), .mr_sel(u_link.mr_sel),
      .mr_addr(u_link.mr_addr));
   always #2 sys_clk = ~sys_clk;
   always #7.5 u_link_b.ck = ~u_link_b.ck;
   initial begin
      u_link_b.ck = 1'b0;
      u_link_b.cke = 1'b1;
      u_link_b.odt = 1'b0;
      u_link_b.cmd = dck_pkg::CMD_NOP;
      u_link_b.mr_sel = 2'h0;
      u_link_b.mr_addr = 16'h0000;
   end
   // ----
   // Tasks
   // ----
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic start(input logic [31:0] ctrl, input logic [7:0] dv);
      apb(1'b1, `DCK_REG_DIV, {24'h0, dv});
      apb(1'b1, `DCK_REG_MR0, 32'h0000_0520);
      apb(1'b1, `DCK_REG_CTRL, ctrl);
   endtask
   task automatic wait_idle;
      apb(1'b0, `DCK_REG_STAT, 32'h0);
      while (rd[0] !== 1'b0) apb(1'b0, `DCK_REG_STAT, 32'h0);
   endtask
   task automatic lb(input dck_pkg::dck_cmd_e c, input logic [15:0] a, input int n);
      @(posedge u_link_b.ck);
      u_link_b.cmd <= c;
      u_link_b.mr_sel <= (a == 16'h0004) ? 2'h1 : 2'h0;
      u_link_b.mr_addr <= a;
      if (c == dck_pkg::CMD_SRE) u_link_b.cke <= 1'b0;
      if (c == dck_pkg::CMD_SRX) u_link_b.cke <= 1'b1;
      @(posedge u_link_b.ck);
      u_link_b.cmd <= dck_pkg::CMD_NOP;
      repeat (n) @(posedge u_link_b.ck);
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors++;
         test_done();
      end
   end
   // ----
   // Main sequence
   // ----
   initial begin
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (20) @(posedge sys_clk);
      link_rst <= 1'b0;
      for (int r = 0; r < 4; r++) begin
         start({28'h0, ROWS[r].upd, ROWS[r].odt, ROWS[r].sr, 1'b1}, ROWS[r].div);
         wait_idle();
         chk(rd, {16'h0, ROWS[r].dexp, 8'h02});
         chk({26'h0, ign_a, lock_a, err_a, rtt_a, st_a}, 32'h0000_0010);
         apb(1'b1, `DCK_REG_STAT, 32'h0000_0002);
         $display("Row %0d finished", r);
      end
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      link_rst <= 1'b1;
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (20) @(posedge sys_clk);
      link_rst <= 1'b0;
      apb(1'b0, `DCK_REG_STAT, 32'h0);
      chk(rd, 32'h0000_0200);
      chk({31'h0, lock_a}, 32'h0);
      $display("Reset test finished");
      start(32'h0000_0001, 8'h03);
      apb(1'b1, `DCK_REG_DIV, 32'h0000_0005);
      apb(1'b1, `DCK_REG_CTRL, 32'h0000_0001);
      apb(1'b0, `DCK_REG_STAT, 32'h0);
      chk(rd & 32'h0000_0005, 32'h0000_0005);
      wait_idle();
      chk(rd, 32'h0000_0306);
      apb(1'b1, `DCK_REG_STAT, 32'h0000_0006);
      apb(1'b0, `DCK_REG_STAT, 32'h0);
      chk(rd, 32'h0000_0300);
      apb(1'b0, 12'h010, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      $display("Busy and unmapped test finished");
      @(posedge u_link_b.ck);
      rst_b <= 1'b0;
      u_link_b.odt <= 1'b1;
      repeat (4) @(posedge u_link_b.ck);
      chk({31'h0, rtt_b}, 32'h0);
      lb(dck_pkg::CMD_MRS, 16'h0004, 4);
      chk({31'h0, rtt_b}, 32'h1);
      u_link_b.odt <= 1'b0;
      lb(dck_pkg::CMD_SRE, 16'h0000, 7);
      chk({29'h0, ign_b, st_b}, 32'h0000_0005);
      lb(dck_pkg::CMD_SRX, 16'h0000, 6);
      chk({31'h0, err_b}, 32'h0);
      // Four edges apart is legal, three edges apart is not
      lb(dck_pkg::CMD_MRS, 16'h0100, 2);
      lb(dck_pkg::CMD_MRS, 16'h0000, 1);
      chk({30'h0, lock_b, err_b}, 32'h0);
      lb(dck_pkg::CMD_MRS, 16'h0000, 2);
      chk({31'h0, err_b}, 32'h1);
      $display("Device end test finished");
      test_done();
   end
endmodule
`default_nettype wire
